// File: pin_cfg_defines.vh
// Purpose: Offsets, field positions and reset values for the pin and interrupt configuration block
// Assumes: 8-bit register port, 4-bit word address
// Notes:   Included by its bare name
`ifndef PIN_CFG_DEFINES_VH
`define PIN_CFG_DEFINES_VH

`define ADDR_W            4
`define DATA_W            8

`define OFF_ASSIGN        4'h0
`define OFF_INT_CTRL      4'h1
`define OFF_PULLUP        4'h2
`define OFF_COND_CODE     4'h3
`define OFF_K_DIR         4'h4
`define OFF_DIG_EN        4'h5
`define OFF_PIN_LEVEL     4'h6
`define OFF_AD_DATA       4'h7
`define OFF_PORT_CTRL     4'h8
`define OFF_KEY_EN        4'h9
`define OFF_EVT_STATUS    4'ha
`define OFF_EVT_MASK      4'hb

`define BIT_STROBE_EN     0
`define BIT_EDGE_MODE     7
`define BIT_PIN_EN        6
`define BIT_PUP_E         4
`define BIT_PUP_K         7
`define BIT_CCR_X         6
`define BIT_CCR_I         4
`define BIT_PE2_DATA      0
`define BIT_PE2_DIR       1
`define BIT_PP7_DATA      2
`define BIT_PP7_DIR       3
`define BIT_EVT_MASKABLE  0
`define BIT_EVT_NONMASK   1
`define BIT_EVT_KEYPAD    2

`define RST_ASSIGN        8'h00
`define RST_INT_CTRL      8'h40
`define RST_PULLUP        8'h90
`define RST_COND_CODE     8'h50
`define RST_K_DIR         8'h00
`define RST_DIG_EN        8'h00
`define RST_PORT_CTRL     8'h00
`define RST_KEY_EN        8'h00
`define RST_EVT_MASK      8'h00

`endif

// File: pin_sync2.v
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Idle level of the pins is high (pulled up)
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none

module pin_sync2 #(
   parameter W = 1
) (
   input  wire         i_ref_clk,
   input  wire         i_rst_n,
   input  wire [W-1:0] i_pin,
   output reg  [W-1:0] o_level
);

   reg [W-1:0] stage1;

   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         stage1  <= {W{1'b1}};
         o_level <= {W{1'b1}};
      end else begin
         stage1  <= i_pin;
         o_level <= stage1;
      end
   end

endmodule // pin_sync2

`default_nettype wire

// File: irq_trigger.v
// Purpose: Falling-edge or low-level trigger for an active-low request pin
// Assumes: i_level_n is already synchronised
// Notes:   Edge requests stay pending until acknowledged or the trigger is disabled
`timescale 1ns/100ps
`default_nettype none

module irq_trigger (
   input  wire i_ref_clk,
   input  wire i_rst_n,
   input  wire i_level_n,
   input  wire i_edge_mode,
   input  wire i_enable,
   input  wire i_ack,
   output reg  o_pending
);

   reg  prev_level;
   wire fall = prev_level & ~i_level_n;

   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         prev_level <= 1'b1;
         o_pending  <= 1'b0;
      end else begin
         prev_level <= i_level_n;
         if (!i_enable)
            o_pending <= 1'b0;
         else if (i_edge_mode)
            o_pending <= fall | (o_pending & ~i_ack);
         else
            o_pending <= ~i_level_n;
      end
   end

endmodule // irq_trigger

`default_nettype wire

// File: port_pin_interrupt_config.v
// Purpose: Pin function, pull-up and external interrupt input logic
// Assumes: Pins synchronous to i_ref_clk except the request pins, which are synchronised
// Notes:   Register port reads answer one cycle after the read strobe
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pin_cfg_defines.vh"

module port_pin_interrupt_config (
   input  wire               i_ref_clk,
   input  wire               i_rst_n,
   // Register port
   input  wire [`ADDR_W-1:0] i_addr,
   input  wire [`DATA_W-1:0] i_wdata,
   input  wire               i_wr,
   input  wire               i_rd,
   output reg  [`DATA_W-1:0] o_rdata,
   // Request pins, active low
   input  wire               i_maskable_pin_n,
   input  wire               i_nonmaskable_interrupt_pin_n,
   output reg                o_request_pins_pullup,
   // Processor side
   input  wire               i_irq_ack,
   output reg                o_maskable_req,
   output reg                o_nonmaskable_req,
   // port_e_pin2
   input  wire               i_port_e_pin2,
   input  wire               i_bus_rw,
   output reg                o_port_e_pin2,
   output reg                o_port_e_pin2_oe,
   output reg                o_port_e_pin2_pullup,
   output reg                o_ext_write_allow,
   // Analog port
   input  wire [7:0]         i_analog_input,
   input  wire               i_conv_multi,
   input  wire [2:0]         i_conv_chan,
   output reg  [7:0]         o_analog_digital,
   output reg  [7:0]         o_conv_sample_sel,
   // port_p_pin7 keypad
   input  wire               i_port_p_pin7,
   output reg                o_port_p_pin7,
   output reg                o_port_p_pin7_oe,
   output reg                o_wake,
   // Port K
   output reg  [7:0]         o_port_k_direction,
   output reg                o_port_k_pullup,
   // Event interrupt
   output reg                o_int_req
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Configuration registers

   reg [7:0] port_e_assignment_reg;
   reg [7:0] interrupt_control_reg;
   reg [7:0] pullup_control_reg;
   reg [7:0] condition_code_reg;
   reg [7:0] port_k_direction;
   reg [7:0] converter_digital_input_enable;
   reg [7:0] port_ctrl;
   reg [7:0] key_en;
   reg [7:0] evt_status;
   reg [7:0] evt_mask;

   wire wr_assign = i_wr & (i_addr == `OFF_ASSIGN);
   wire wr_intctl = i_wr & (i_addr == `OFF_INT_CTRL);
   wire wr_pullup = i_wr & (i_addr == `OFF_PULLUP);
   wire wr_ccr    = i_wr & (i_addr == `OFF_COND_CODE);
   wire wr_kdir   = i_wr & (i_addr == `OFF_K_DIR);
   wire wr_digen  = i_wr & (i_addr == `OFF_DIG_EN);
   wire wr_pctrl  = i_wr & (i_addr == `OFF_PORT_CTRL);
   wire wr_keyen  = i_wr & (i_addr == `OFF_KEY_EN);
   wire wr_status = i_wr & (i_addr == `OFF_EVT_STATUS);
   wire wr_mask   = i_wr & (i_addr == `OFF_EVT_MASK);

   wire strobe_output_enable  = port_e_assignment_reg[`BIT_STROBE_EN];
   wire edge_mode             = interrupt_control_reg[`BIT_EDGE_MODE];
   wire maskable_pin_enable   = interrupt_control_reg[`BIT_PIN_EN];
   wire port_e_pullup_enable  = pullup_control_reg[`BIT_PUP_E];
   wire port_k_pullup_enable  = pullup_control_reg[`BIT_PUP_K];
   wire ccr_x                 = condition_code_reg[`BIT_CCR_X];
   wire ccr_i                 = condition_code_reg[`BIT_CCR_I];
   wire pe2_dir               = port_ctrl[`BIT_PE2_DIR];
   wire pp7_dir               = port_ctrl[`BIT_PP7_DIR];

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Request pin synchroniser and maskable request trigger

   wire [1:0] req_level_n;
   wire       maskable_pending;

   pin_sync2 #(
      .W (2)
   ) u_req_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_pin     ({i_nonmaskable_interrupt_pin_n, i_maskable_pin_n}),
      .o_level   (req_level_n)
   );

   wire maskable_level_n    = req_level_n[0];
   wire nonmaskable_level_n = req_level_n[1];

   irq_trigger u_maskable_trig (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_level_n   (maskable_level_n),
      .i_edge_mode (edge_mode),
      .i_enable    (maskable_pin_enable),
      .i_ack       (i_irq_ack),
      .o_pending   (maskable_pending)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Keypad edge on port_p_pin7

   reg  pp7_prev;
   wire key_fall = pp7_prev & ~i_port_p_pin7 & ~pp7_dir & key_en[0];

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next values of outputs

   wire next_maskable_req    = maskable_pending & ~ccr_i;
   wire next_nonmaskable_req = ~nonmaskable_level_n & ~ccr_x;

   reg  [7:0] evt_set;
   reg  [7:0] next_status;
   reg  [7:0] next_conv_sel;

   always @* begin
      evt_set                    = 8'h00;
      evt_set[`BIT_EVT_MASKABLE] = next_maskable_req & ~o_maskable_req;
      evt_set[`BIT_EVT_NONMASK]  = next_nonmaskable_req & ~o_nonmaskable_req;
      evt_set[`BIT_EVT_KEYPAD]   = key_fall;
      // A new event in the clearing cycle survives the clear
      next_status = (evt_status & ~(wr_status ? i_wdata : 8'h00)) | evt_set;
   end

   always @* begin
      if (i_conv_multi)
         next_conv_sel = 8'hff;
      else
         next_conv_sel = 8'h01 << i_conv_chan;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Read data

   reg [7:0] next_rdata;

   always @* begin
      case (i_addr)
         `OFF_ASSIGN:     next_rdata = port_e_assignment_reg;
         `OFF_INT_CTRL:   next_rdata = interrupt_control_reg;
         `OFF_PULLUP:     next_rdata = pullup_control_reg;
         `OFF_COND_CODE:  next_rdata = condition_code_reg;
         `OFF_K_DIR:      next_rdata = port_k_direction;
         `OFF_DIG_EN:     next_rdata = converter_digital_input_enable;
         `OFF_PIN_LEVEL:  next_rdata = {5'h00, i_port_e_pin2,
                                        maskable_level_n, nonmaskable_level_n};
         `OFF_AD_DATA:    next_rdata = i_analog_input & converter_digital_input_enable;
         `OFF_PORT_CTRL:  next_rdata = {port_ctrl[7:3], i_port_p_pin7, port_ctrl[1:0]};
         `OFF_KEY_EN:     next_rdata = key_en;
         `OFF_EVT_STATUS: next_rdata = evt_status;
         `OFF_EVT_MASK:   next_rdata = evt_mask;
         default:         next_rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register file

   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         port_e_assignment_reg          <= `RST_ASSIGN;
         interrupt_control_reg          <= `RST_INT_CTRL;
         pullup_control_reg             <= `RST_PULLUP;
         condition_code_reg             <= `RST_COND_CODE;
         port_k_direction               <= `RST_K_DIR;
         converter_digital_input_enable <= `RST_DIG_EN;
         port_ctrl                      <= `RST_PORT_CTRL;
         key_en                         <= `RST_KEY_EN;
         evt_status                     <= 8'h00;
         evt_mask                       <= `RST_EVT_MASK;
         pp7_prev                       <= 1'b1;
      end else begin
         if (wr_assign)
            port_e_assignment_reg <= i_wdata;
         if (wr_intctl)
            interrupt_control_reg <= i_wdata;
         if (wr_pullup)
            pullup_control_reg <= i_wdata;
         if (wr_ccr) begin
            // X may only be cleared by software, never set again
            condition_code_reg            <= i_wdata;
            condition_code_reg[`BIT_CCR_X] <= ccr_x & i_wdata[`BIT_CCR_X];
         end
         if (wr_kdir)
            port_k_direction <= i_wdata;
         if (wr_digen)
            converter_digital_input_enable <= i_wdata;
         if (wr_pctrl)
            port_ctrl <= i_wdata;
         if (wr_keyen)
            key_en <= i_wdata;
         if (wr_mask)
            evt_mask <= i_wdata;
         evt_status <= next_status;
         pp7_prev   <= i_port_p_pin7;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Registered outputs

   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_rdata               <= 8'h00;
         o_request_pins_pullup <= 1'b1;
         o_maskable_req        <= 1'b0;
         o_nonmaskable_req     <= 1'b0;
         o_port_e_pin2         <= 1'b0;
         o_port_e_pin2_oe      <= 1'b0;
         o_port_e_pin2_pullup  <= 1'b1;
         o_ext_write_allow     <= 1'b0;
         o_analog_digital      <= 8'h00;
         o_conv_sample_sel     <= 8'h00;
         o_port_p_pin7         <= 1'b0;
         o_port_p_pin7_oe      <= 1'b0;
         o_wake                <= 1'b0;
         o_port_k_direction    <= 8'h00;
         o_port_k_pullup       <= 1'b1;
         o_int_req             <= 1'b0;
      end else begin
         o_rdata               <= i_rd ? next_rdata : 8'h00;
         o_request_pins_pullup <= port_e_pullup_enable;
         o_maskable_req        <= next_maskable_req;
         o_nonmaskable_req     <= next_nonmaskable_req;
         // Strobe takes the pin over from the port logic once enabled
         if (strobe_output_enable) begin
            o_port_e_pin2    <= i_bus_rw;
            o_port_e_pin2_oe <= 1'b1;
         end else begin
            o_port_e_pin2    <= port_ctrl[`BIT_PE2_DATA];
            o_port_e_pin2_oe <= pe2_dir;
         end
         o_port_e_pin2_pullup <= port_e_pullup_enable & ~strobe_output_enable & ~pe2_dir;
         o_ext_write_allow    <= strobe_output_enable;
         o_analog_digital     <= i_analog_input & converter_digital_input_enable;
         o_conv_sample_sel    <= next_conv_sel;
         o_port_p_pin7        <= port_ctrl[`BIT_PP7_DATA];
         o_port_p_pin7_oe     <= pp7_dir;
         // Wake is held from the sticky bit so it outlasts a stopped core clock request
         o_wake               <= next_status[`BIT_EVT_KEYPAD];
         o_port_k_direction   <= port_k_direction;
         o_port_k_pullup      <= port_k_pullup_enable;
         o_int_req            <= |(next_status & evt_mask);
      end
   end

endmodule // port_pin_interrupt_config

`default_nettype wire

// File: port_pin_interrupt_config_checker.sv
// Purpose: Port-level assertions for the pin and request configuration block
// Assumes: Latencies and register port timing as agreed in the hand-over
// Notes:   Bound to the design top from the testbench top file
`timescale 1ns/100ps
`default_nettype none

module port_pin_interrupt_config_checker (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_rd,
   input  wire logic       i_wr,
   input  wire logic [7:0] o_rdata,
   input  wire logic       i_maskable_pin_n,
   input  wire logic       i_nonmaskable_interrupt_pin_n,
   input  wire logic       o_maskable_req,
   input  wire logic       o_nonmaskable_req,
   input  wire logic       o_request_pins_pullup,
   input  wire logic       o_port_e_pin2_oe,
   input  wire logic       o_port_e_pin2_pullup,
   input  wire logic       o_ext_write_allow,
   input  wire logic       i_bus_rw,
   input  wire logic       o_port_e_pin2,
   input  wire logic [7:0] i_analog_input,
   input  wire logic [7:0] o_analog_digital,
   input  wire logic       i_conv_multi,
   input  wire logic [2:0] i_conv_chan,
   input  wire logic [7:0] o_conv_sample_sel,
   input  wire logic       i_port_p_pin7,
   input  wire logic       o_wake,
   input  wire logic [7:0] o_port_k_direction,
   input  wire logic       o_port_k_pullup,
   input  wire logic       o_int_req
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   reset_state_a: assert property ($rose(i_rst_n) |-> o_request_pins_pullup && o_port_k_pullup
      && o_port_e_pin2_pullup && !o_port_e_pin2_oe && o_port_k_direction == 8'h00)
      else $error("pin state wrong right after reset");
   strobe_drive_a: assert property (o_ext_write_allow && $past(o_ext_write_allow, 2)
      |-> o_port_e_pin2_oe && !o_port_e_pin2_pullup)
      else $error("strobe enabled but pin not driven");
   strobe_follow_a: assert property (o_ext_write_allow |-> o_port_e_pin2 == $past(i_bus_rw))
      else $error("pin not following bus read/write level");
   nmi_level_a: assert property (o_nonmaskable_req
      |-> !$past(i_nonmaskable_interrupt_pin_n, 3) || !$past(i_nonmaskable_interrupt_pin_n, 4))
      else $error("non-maskable request without low pin");
   irq_cause_a: assert property ($rose(o_maskable_req)
      |-> !$past(i_maskable_pin_n, 4) || !$past(i_maskable_pin_n, 5))
      else $error("maskable request without low pin");
   wake_cause_a: assert property ($rose(o_wake)
      |-> !$past(i_port_p_pin7) || !$past(i_port_p_pin7, 2) || !$past(i_port_p_pin7, 3))
      else $error("wake without keypad pin low");
   int_clear_a: assert property ($fell(o_int_req) |-> $past(i_wr) || $past(i_wr, 2))
      else $error("interrupt dropped without a write");
   conv_select_a: assert property ($past(i_rst_n) |-> o_conv_sample_sel ==
      ($past(i_conv_multi) ? 8'hff : 8'h01 << $past(i_conv_chan)))
      else $error("converter channel selection wrong");
   analog_gate_a: assert property ($past(i_rst_n)
      |-> (o_analog_digital & ~$past(i_analog_input)) == 8'h00)
      else $error("analog digital value not from pins");

   cover property ($rose(o_maskable_req));
   cover property ($rose(o_nonmaskable_req));
   cover property ($rose(o_wake));
endmodule // port_pin_interrupt_config_checker

`default_nettype wire

// File: irq_source_model.sv
// Purpose: Board-side request sources on the two request pins
// Assumes: Sources are open-drain and only ever pull low
// Notes:   A line without pull-up floats; modelled as a toggling level
`timescale 1ns/100ps
`default_nettype none

module irq_source_model (
   input  wire logic       i_ref_clk,
   input  wire logic       i_pullup,
   input  wire logic [1:0] i_nm_pull,
   input  wire logic       i_m_pull,
   output logic            o_nm_n,
   output logic            o_m_n
);
   logic tog = 1'b0;

   // A floating pin must not settle to a convenient value
   always @(posedge i_ref_clk) begin
      tog <= ~tog;
   end
   // Two sources share the non-maskable line as a wired-OR, low requests
   assign o_nm_n = (|i_nm_pull) ? 1'b0 : (i_pullup ? 1'b1 : tog);
   assign o_m_n  = i_m_pull ? 1'b0 : (i_pullup ? 1'b1 : tog);
endmodule // irq_source_model

`default_nettype wire

// File: port_pin_interrupt_config_tb.sv
// Purpose: Self-checking bench for the pin and request configuration block
// Assumes: Register map and latencies as agreed in the hand-over
// Notes:   m[] holds the expected read value of addresses 0 to 12
`timescale 1ns/100ps
`default_nettype none

module port_pin_interrupt_config_tb;
   logic        i_ref_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic [3:0]  i_addr = 4'h0;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        i_irq_ack = 1'b0;
   logic        i_bus_rw = 1'b0;
   logic [7:0]  i_analog_input = 8'h00;
   logic        i_conv_multi = 1'b0;
   logic [2:0]  i_conv_chan = 3'h0;
   logic        i_port_p_pin7 = 1'b1;
   logic [1:0]  nm_pull = 2'b00;
   logic        m_pull = 1'b0;
   logic [31:0] rword;
   logic [7:0]  ain_seen = 8'h00;
   wire         m_n, nm_n, req_pullup, m_req, nm_req, wake, int_req, e2_oe, allow, k_pullup;
   wire  [7:0]  rdata, k_dir;
   int          n_mismatch = 0;
   int          checked = 0;
   int unsigned seed = 49;
   logic [7:0]  m [0:12];

   port_pin_interrupt_config port_pin_interrupt_config_i (.i_ref_clk, .i_rst_n, .i_addr,
      .i_wdata, .i_wr, .i_rd, .o_rdata(rdata), .i_maskable_pin_n(m_n),
      .i_nonmaskable_interrupt_pin_n(nm_n), .o_request_pins_pullup(req_pullup), .i_irq_ack,
      .o_maskable_req(m_req), .o_nonmaskable_req(nm_req), .i_port_e_pin2(1'b1), .i_bus_rw,
      .o_port_e_pin2(), .o_port_e_pin2_oe(e2_oe), .o_port_e_pin2_pullup(),
      .o_ext_write_allow(allow), .i_analog_input, .i_conv_multi, .i_conv_chan,
      .o_analog_digital(), .o_conv_sample_sel(), .i_port_p_pin7, .o_port_p_pin7(),
      .o_port_p_pin7_oe(), .o_wake(wake), .o_port_k_direction(k_dir),
      .o_port_k_pullup(k_pullup), .o_int_req(int_req));
   irq_source_model irq_source_model_i (.i_ref_clk, .i_pullup(req_pullup), .i_nm_pull(nm_pull),
      .i_m_pull(m_pull), .o_nm_n(nm_n), .o_m_n(m_n));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("Counts: %0d checks, %0d mismatches", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Writes also update the model: X bit only clears, status is write-one-to-clear
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      case (a)
         4'h3: m[3] = {d[7], m[3][6] & d[6], d[5:0]};
         4'ha: m[10] = m[10] & ~d;
         4'h6, 4'h7, 4'hc: ;
         default: m[a] = d;
      endcase
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      // Converter data reads the pin levels the design sampled with the strobe
      #1 if (a == 4'h7) m[7] = ain_seen & m[5];
      chk("read data", rdata, m[a]);
   endtask
   task automatic check_all();
      for (int a = 0; a < 13; a++) rd(a[3:0]);
   endtask
   task automatic pins(input logic [1:0] nm, input logic mp);
      @(posedge i_ref_clk);
      nm_pull <= nm;
      m_pull <= mp;
   endtask
   task automatic wait_on(input int which, input logic v);
      int k;
      logic [3:0] s;
      for (k = 0; k < 40; k++) begin
         @(posedge i_ref_clk);
         #1 s = {int_req, wake, nm_req, m_req};
         if (s[which] === v) break;
      end
      chk("request wait", {7'h00, s[which]}, {7'h00, v});
      if (k == 40) summarize();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   always @(posedge i_ref_clk) begin
      rword = rnd();
      ain_seen <= i_analog_input;
      i_analog_input <= rword[7:0];
      i_conv_multi <= rword[8];
      i_conv_chan <= rword[11:9];
      i_bus_rw <= rword[12];
   end
   initial begin
      logic [31:0] v;
      m = '{8'h00, 8'h40, 8'h90, 8'h50, 8'h00, 8'h00, 8'h07, 8'h00, 8'h04, 8'h00, 8'h00,
            8'h00, 8'h00};
      repeat (3) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      check_all();
      v = rnd();
      wr(4'h4, v[7:0]);
      wr(4'h5, v[15:8]);
      wr(4'h6, 8'hff);
      wr(4'h7, 8'hff);
      wr(4'hc, 8'hff);
      #1 chk("port K direction", k_dir, v[7:0]);
      rd(4'h5);
      rd(4'h7);
      rd(4'h6);
      rd(4'hc);
      repeat (20) @(posedge i_ref_clk);
      wr(4'h5, 8'h00);
      wr(4'h4, 8'h00);
      pins(2'b11, 1'b0);
      repeat (8) @(posedge i_ref_clk);
      #1 chk("masked nmi", {7'h00, nm_req}, 8'h00);
      wr(4'h3, 8'h10);
      wait_on(1, 1'b1);
      pins(2'b01, 1'b0);
      repeat (6) @(posedge i_ref_clk);
      #1 chk("shared nmi", {7'h00, nm_req}, 8'h01);
      pins(2'b00, 1'b0);
      wait_on(1, 1'b0);
      wr(4'h3, 8'h50);
      rd(4'h3);
      m[10] = 8'h02;
      pins(2'b00, 1'b1);
      repeat (8) @(posedge i_ref_clk);
      #1 chk("masked irq", {7'h00, m_req}, 8'h00);
      m[6] = 8'h05;
      rd(4'h6);
      m[6] = 8'h07;
      wr(4'h3, 8'h00);
      wait_on(0, 1'b1);
      wr(4'h1, 8'h00);
      wait_on(0, 1'b0);
      pins(2'b00, 1'b0);
      m[10] = 8'h03;
      repeat (4) @(posedge i_ref_clk);
      check_all();
      wr(4'hb, 8'h03);
      wait_on(3, 1'b1);
      wr(4'ha, 8'h03);
      wait_on(3, 1'b0);
      wr(4'h1, 8'hc0);
      pins(2'b00, 1'b1);
      repeat (2) @(posedge i_ref_clk);
      pins(2'b00, 1'b0);
      wait_on(0, 1'b1);
      repeat (6) @(posedge i_ref_clk);
      #1 chk("edge pending", {7'h00, m_req}, 8'h01);
      @(posedge i_ref_clk);
      i_irq_ack <= 1'b1;
      @(posedge i_ref_clk);
      i_irq_ack <= 1'b0;
      wait_on(0, 1'b0);
      m[10] = 8'h01;
      rd(4'ha);
      wr(4'ha, 8'hff);
      wr(4'h9, 8'h01);
      @(posedge i_ref_clk);
      i_port_p_pin7 <= 1'b0;
      wait_on(2, 1'b1);
      m[10] = 8'h04;
      rd(4'ha);
      @(posedge i_ref_clk);
      i_port_p_pin7 <= 1'b1;
      wr(4'ha, 8'h04);
      wait_on(2, 1'b0);
      #1 chk("pin2 drive", {7'h00, e2_oe}, 8'h00);
      wr(4'h0, 8'h01);
      @(posedge i_ref_clk);
      #1 chk("write allow", {6'h00, allow, e2_oe}, 8'h03);
      check_all();
      wr(4'h2, 8'h00);
      @(posedge i_ref_clk);
      #1 chk("pull-ups", {6'h00, req_pullup, k_pullup}, 8'h00);
      summarize();
   end
endmodule // port_pin_interrupt_config_tb

bind port_pin_interrupt_config port_pin_interrupt_config_checker
   port_pin_interrupt_config_checker_i (.i_ref_clk, .i_rst_n, .i_rd, .i_wr, .o_rdata,
   .i_maskable_pin_n, .i_nonmaskable_interrupt_pin_n, .o_maskable_req, .o_nonmaskable_req,
   .o_request_pins_pullup, .o_port_e_pin2_oe, .o_port_e_pin2_pullup, .o_ext_write_allow,
   .i_bus_rw, .o_port_e_pin2,
   .i_analog_input, .o_analog_digital, .i_conv_multi, .i_conv_chan, .o_conv_sample_sel,
   .i_port_p_pin7, .o_wake, .o_port_k_direction, .o_port_k_pullup, .o_int_req);

`default_nettype wire
